/* common/leas_pkg.sv */
package leas_pkg;

   // ---------------------------------------------------------------
   // Widths
   // ---------------------------------------------------------------
   localparam int ADDR_W = 32;
   localparam int DATA_W = 64;

   // ---------------------------------------------------------------
   // Access sizes, instruction classes and unit states
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      LEAS_SZ1 = 2'h0,
      LEAS_SZ2 = 2'h1,
      LEAS_SZ4 = 2'h2,
      LEAS_SZ8 = 2'h3
   } leas_size_e;

   typedef enum logic [1:0] {
      LEAS_CL_SINGLE  = 2'h0,
      LEAS_CL_MULTI   = 2'h1,
      LEAS_CL_STRING  = 2'h2,
      LEAS_CL_BARRIER = 2'h3
   } leas_class_e;

   typedef enum logic [2:0] {
      LEAS_IDLE  = 3'h1,
      LEAS_ISSUE = 3'h2,
      LEAS_SPLIT = 3'h4
   } leas_state_e;

   // ---------------------------------------------------------------
   // Byte order encodings and address modifiers
   // ---------------------------------------------------------------
   localparam logic ORDER_BIG = 1'h0;
   localparam logic ORDER_LITTLE = 1'h1;
   localparam logic [2:0] XOR_8B = 3'h0;
   localparam logic [2:0] XOR_4B = 3'h4;
   localparam logic [2:0] XOR_2B = 3'h6;
   localparam logic [2:0] XOR_1B = 3'h7;
   localparam logic [3:0] DWORD_BYTES = 4'h8;

   // ---------------------------------------------------------------
   // Fetch stepping and reset values
   // ---------------------------------------------------------------
   localparam logic [31:0] INSN_STEP = 32'h0000_0004;
   localparam logic [31:0] RST_PC = 32'h0000_0000;
   localparam logic RST_CUR_ORDER = 1'h0;
   localparam logic RST_HND_ORDER = 1'h0;

endpackage

/* sim/leas_mem_model.sv */
`timescale 1ns/10ps
module leas_mem_model
   import leas_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk_in,
   input wire logic reset_in,
   // Memory request from the unit
   input wire logic mem_valid_in,
   output logic mem_ready_out,
   input wire logic [31:0] mem_addr_in,
   input wire leas_size_e mem_size_in,
   input wire logic mem_direct_in,
   input wire logic mem_store_in,
   input wire logic [63:0] mem_wdata_in,
   output logic [63:0] mem_rdata_out,
   // Bench control and record
   input wire logic [3:0] stall_in,
   output logic [7:0] beats_out,
   output logic [31:0] prev_addr_out,
   output logic [31:0] last_addr_out,
   output logic [63:0] last_wdata_out,
   output logic last_direct_out,
   output logic last_store_out
);
   logic [3:0] wait_cnt;
   logic [63:0] pat;
   always_comb begin
      // Same byte values at any width: every byte is the low address byte, masked to the access size
      pat = {8{mem_addr_in[7:0]}};
      case (mem_size_in)
         LEAS_SZ1: pat = pat & 64'h0000_0000_0000_00ff;
         LEAS_SZ2: pat = pat & 64'h0000_0000_0000_ffff;
         LEAS_SZ4: pat = pat & 64'h0000_0000_ffff_ffff;
         default: pat = pat;
      endcase
   end
   assign mem_ready_out = mem_valid_in && (wait_cnt >= stall_in);
   // Data off the handshake is inverted so a stale sample cannot match
   assign mem_rdata_out = mem_ready_out ? pat : ~pat;
   always_ff @(posedge sys_clk_in or posedge reset_in) begin
      if (reset_in) begin
         wait_cnt <= 4'h0;
         beats_out <= 8'h00;
         prev_addr_out <= 32'h0;
         last_addr_out <= 32'h0;
         last_wdata_out <= 64'h0;
         last_direct_out <= 1'b0;
         last_store_out <= 1'b0;
      end else if (mem_ready_out) begin
         wait_cnt <= 4'h0;
         beats_out <= beats_out + 8'h01;
         prev_addr_out <= last_addr_out;
         last_addr_out <= mem_addr_in;
         last_wdata_out <= mem_wdata_in;
         last_direct_out <= mem_direct_in;
         last_store_out <= mem_store_in;
      end else if (mem_valid_in) begin
         wait_cnt <= wait_cnt + 4'h1;
      end
   end
endmodule

/* sim/test_little_endian_address_swizzle.sv */
`timescale 1ns/10ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_fail++; \
   $display("FAIL t=%0t got %h exp %h", $time, (a), (b)); end end
module test_little_endian_address_swizzle
   import leas_pkg::*;
;
   typedef struct {
      logic cur; logic [31:0] ea; leas_size_e sz; leas_class_e cl;
      logic st; logic dir; logic exc; logic [31:0] addr; logic [7:0] nb;
   } leas_row_s;
   logic sys_clk_in = 0, reset_in = 1, mode_write_in = 0, mode_cur_in = 0, mode_hnd_in = 0;
   logic exc_take_in = 0, split_enable_in = 0, fetch_advance_in = 0, branch_in = 0;
   logic branch_abs_in = 0, branch_link_in = 0, req_valid_in = 0, req_store_in = 0;
   logic req_direct_in = 0, mem_ready_in, cur_order_out, hnd_order_out, req_ready_out;
   logic resp_valid_out, resp_align_exc_out, mem_valid_out, mem_store_out, mem_direct_out;
   logic last_direct, last_store;
   logic [31:0] exc_vector_in = 0, branch_target_in = 0, branch_offset_in = 0, req_ea_in = 0;
   logic [31:0] fetch_pc_out, fetch_addr_out, link_out, saved_pc_out, mem_addr_out;
   logic [31:0] prev_addr, last_addr;
   logic [63:0] req_wdata_in = 0, resp_rdata_out, mem_wdata_out, mem_rdata_in, last_wdata;
   leas_size_e req_size_in = LEAS_SZ1, mem_size_out;
   leas_class_e req_class_in = LEAS_CL_SINGLE;
   logic [3:0] stall = 0;
   logic [7:0] beats, b0;
   int n_fail = 0, n_checks = 0;
   leas_row_s rows [12] = '{
      '{0, 32'h10, LEAS_SZ4, LEAS_CL_SINGLE, 0, 0, 0, 32'h10, 8'h1},
      '{1, 32'h18, LEAS_SZ8, LEAS_CL_SINGLE, 0, 0, 0, 32'h18, 8'h1},
      '{1, 32'h10, LEAS_SZ4, LEAS_CL_SINGLE, 0, 0, 0, 32'h14, 8'h1},
      '{1, 32'h12, LEAS_SZ2, LEAS_CL_SINGLE, 0, 0, 0, 32'h14, 8'h1},
      '{1, 32'h11, LEAS_SZ1, LEAS_CL_SINGLE, 0, 0, 0, 32'h16, 8'h1},
      '{1, 32'h20, LEAS_SZ4, LEAS_CL_SINGLE, 1, 1, 0, 32'h24, 8'h1},
      '{0, 32'h05, LEAS_SZ4, LEAS_CL_SINGLE, 0, 0, 0, 32'h05, 8'h1},
      '{1, 32'h05, LEAS_SZ4, LEAS_CL_SINGLE, 0, 0, 1, 32'h0, 8'h0},
      '{1, 32'h10, LEAS_SZ4, LEAS_CL_MULTI, 0, 0, 1, 32'h0, 8'h0},
      '{1, 32'h10, LEAS_SZ1, LEAS_CL_STRING, 0, 0, 1, 32'h0, 8'h0},
      '{1, 32'h10, LEAS_SZ4, LEAS_CL_BARRIER, 0, 0, 0, 32'h0, 8'h0},
      '{1, 32'h03, LEAS_SZ2, LEAS_CL_SINGLE, 0, 0, 1, 32'h0, 8'h0}
   };
   initial begin
      forever #10 sys_clk_in = ~sys_clk_in;
   end
   leas_unit dut_u (.sys_clk_in(sys_clk_in), .reset_in(reset_in),
      .mode_write_in(mode_write_in), .mode_cur_in(mode_cur_in), .mode_hnd_in(mode_hnd_in),
      .exc_take_in(exc_take_in), .exc_vector_in(exc_vector_in),
      .cur_order_out(cur_order_out), .hnd_order_out(hnd_order_out),
      .split_enable_in(split_enable_in), .fetch_advance_in(fetch_advance_in),
      .branch_in(branch_in), .branch_abs_in(branch_abs_in), .branch_link_in(branch_link_in),
      .branch_target_in(branch_target_in), .branch_offset_in(branch_offset_in),
      .fetch_pc_out(fetch_pc_out), .fetch_addr_out(fetch_addr_out), .link_out(link_out),
      .saved_pc_out(saved_pc_out), .req_valid_in(req_valid_in),
      .req_ready_out(req_ready_out), .req_ea_in(req_ea_in), .req_size_in(req_size_in),
      .req_class_in(req_class_in), .req_store_in(req_store_in),
      .req_direct_in(req_direct_in), .req_wdata_in(req_wdata_in),
      .resp_valid_out(resp_valid_out), .resp_align_exc_out(resp_align_exc_out),
      .resp_rdata_out(resp_rdata_out), .mem_valid_out(mem_valid_out),
      .mem_ready_in(mem_ready_in), .mem_addr_out(mem_addr_out), .mem_size_out(mem_size_out),
      .mem_store_out(mem_store_out), .mem_direct_out(mem_direct_out),
      .mem_wdata_out(mem_wdata_out), .mem_rdata_in(mem_rdata_in));
   leas_mem_model mem_u (.sys_clk_in(sys_clk_in), .reset_in(reset_in),
      .mem_valid_in(mem_valid_out), .mem_ready_out(mem_ready_in), .mem_addr_in(mem_addr_out),
      .mem_size_in(mem_size_out), .mem_direct_in(mem_direct_out),
      .mem_store_in(mem_store_out),
      .mem_wdata_in(mem_wdata_out), .mem_rdata_out(mem_rdata_in), .stall_in(stall),
      .beats_out(beats), .prev_addr_out(prev_addr), .last_addr_out(last_addr),
      .last_wdata_out(last_wdata), .last_direct_out(last_direct), .last_store_out(last_store));
   // ---------------------------------------------------------------
   // Closing and drivers
   // ---------------------------------------------------------------
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic set_mode(input logic cur, input logic hnd);
      @(posedge sys_clk_in);
      mode_write_in <= 1'b1;
      mode_cur_in <= cur;
      mode_hnd_in <= hnd;
      @(posedge sys_clk_in);
      mode_write_in <= 1'b0;
      #1;
   endtask
   task automatic do_req(input logic [31:0] ea, input leas_size_e sz, input leas_class_e cl,
         input logic st, input logic dir);
      int i;
      @(posedge sys_clk_in);
      req_valid_in <= 1'b1;
      req_ea_in <= ea;
      req_size_in <= sz;
      req_class_in <= cl;
      req_store_in <= st;
      req_direct_in <= dir;
      req_wdata_in <= {32'hfeed_0000, ea};
      for (i = 0; i < 50 && req_ready_out !== 1'b1; i++) @(negedge sys_clk_in);
      if (req_ready_out !== 1'b1) begin
         n_fail++;
         $display("FAIL t=%0t request never accepted", $time);
         end_of_test();
      end
      @(posedge sys_clk_in);
      req_valid_in <= 1'b0;
      for (i = 0; i < 50; i++) begin
         #1;
         if (resp_valid_out === 1'b1) break;
         @(posedge sys_clk_in);
      end
      if (i == 50) begin
         n_fail++;
         $display("FAIL t=%0t no response", $time);
         end_of_test();
      end
   endtask
   task automatic ev(input int kind);
      @(posedge sys_clk_in);
      fetch_advance_in <= (kind == 0);
      branch_in <= (kind == 1);
      exc_take_in <= (kind == 2);
      @(posedge sys_clk_in);
      {fetch_advance_in, branch_in, exc_take_in} <= 3'h0;
      #1;
   endtask
   function automatic logic [63:0] size_mask(input leas_size_e sz);
      return (sz == LEAS_SZ8) ? 64'hffff_ffff_ffff_ffff : (64'h1 << (8 << sz)) - 64'h1;
   endfunction
   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (4) @(posedge sys_clk_in);
      reset_in <= 1'b0;
      #1;
      `CHK({cur_order_out, hnd_order_out, req_ready_out, mem_valid_out}, 4'h2)
      `CHK(fetch_pc_out, RST_PC)
      $display("reset test done");
      foreach (rows[k]) begin
         stall <= 4'(k % 3);
         set_mode(rows[k].cur, rows[k].cur);
         `CHK(cur_order_out, rows[k].cur)
         b0 = beats;
         do_req(rows[k].ea, rows[k].sz, rows[k].cl, rows[k].st, rows[k].dir);
         `CHK(resp_align_exc_out, rows[k].exc)
         #21;
         `CHK(beats - b0, rows[k].nb)
         if (rows[k].nb != 0) begin
            `CHK(last_addr, rows[k].addr)
            `CHK(last_store, rows[k].st)
            if (rows[k].st) begin
               `CHK(last_wdata, {32'hfeed_0000, rows[k].ea})
               `CHK(last_direct, 1'b1)
            end else begin
               `CHK(resp_rdata_out, {8{rows[k].addr[7:0]}} & size_mask(rows[k].sz))
            end
         end
      end
      $display("table test done");
      split_enable_in <= 1'b1;
      stall <= 4'h2;
      b0 = beats;
      do_req(32'h03, LEAS_SZ2, LEAS_CL_SINGLE, 1'b0, 1'b0);
      `CHK(resp_align_exc_out, 1'b0)
      `CHK(resp_rdata_out, 64'h0304)
      #21;
      `CHK({prev_addr, last_addr, beats - b0}, {32'h04, 32'h03, 8'h2})
      $display("split test done");
      set_mode(1'b1, 1'b0);
      ev(0);
      `CHK({fetch_pc_out, fetch_addr_out}, {32'h4, 32'h0})
      ev(0);
      `CHK({fetch_pc_out, fetch_addr_out}, {32'h8, 32'hc})
      branch_link_in <= 1'b1;
      branch_offset_in <= 32'h100;
      ev(1);
      `CHK({fetch_pc_out, link_out, fetch_addr_out}, {32'h108, 32'hc, 32'h10c})
      branch_abs_in <= 1'b1;
      branch_link_in <= 1'b0;
      branch_target_in <= 32'h200;
      ev(1);
      `CHK({fetch_pc_out, fetch_addr_out}, {32'h200, 32'h204})
      exc_vector_in <= 32'h300;
      ev(2);
      `CHK({cur_order_out, saved_pc_out, fetch_pc_out}, {1'b0, 32'h200, 32'h300})
      `CHK(fetch_addr_out, 32'h300)
      // Handler entered little endian: its first word sits in the swapped slot
      set_mode(1'b0, 1'b1);
      ev(2);
      `CHK({cur_order_out, fetch_addr_out}, {1'b1, 32'h304})
      $display("fetch test done");
      reset_in <= 1'b1;
      #5;
      `CHK({fetch_pc_out, resp_valid_out, req_ready_out}, {32'h0, 2'h1})
      @(posedge sys_clk_in);
      reset_in <= 1'b0;
      b0 = beats;
      do_req(32'h0c, LEAS_SZ4, LEAS_CL_SINGLE, 1'b0, 1'b0);
      `CHK({resp_align_exc_out, last_addr, beats - b0}, {1'b0, 32'h0c, 8'h01})
      $display("second reset test done");
      end_of_test();
   end
endmodule

/* verilog/leas_unit.sv */
`timescale 1ns/10ps
module leas_unit
   import leas_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk_in,
   input wire logic reset_in,
   // Byte order mode control
   input wire logic mode_write_in,
   input wire logic mode_cur_in,
   input wire logic mode_hnd_in,
   input wire logic exc_take_in,
   input wire logic [31:0] exc_vector_in,
   output logic cur_order_out,
   output logic hnd_order_out,
   // Misaligned handling option
   input wire logic split_enable_in,
   // Instruction fetch and branches
   input wire logic fetch_advance_in,
   input wire logic branch_in,
   input wire logic branch_abs_in,
   input wire logic branch_link_in,
   input wire logic [31:0] branch_target_in,
   input wire logic [31:0] branch_offset_in,
   output logic [31:0] fetch_pc_out,
   output logic [31:0] fetch_addr_out,
   output logic [31:0] link_out,
   output logic [31:0] saved_pc_out,
   // Data request from the core
   input wire logic req_valid_in,
   output logic req_ready_out,
   input wire logic [31:0] req_ea_in,
   input wire leas_size_e req_size_in,
   input wire leas_class_e req_class_in,
   input wire logic req_store_in,
   input wire logic req_direct_in,
   input wire logic [63:0] req_wdata_in,
   // Answer to the core
   output logic resp_valid_out,
   output logic resp_align_exc_out,
   output logic [63:0] resp_rdata_out,
   // Memory side
   output logic mem_valid_out,
   input wire logic mem_ready_in,
   output logic [31:0] mem_addr_out,
   output leas_size_e mem_size_out,
   output logic mem_store_out,
   output logic mem_direct_out,
   output logic [63:0] mem_wdata_out,
   input wire logic [63:0] mem_rdata_in
);

   // ---------------------------------------------------------------
   // Decoding helpers
   // ---------------------------------------------------------------
   function automatic logic [3:0] size_bytes(input leas_size_e sz);
      case (sz)
         LEAS_SZ1: size_bytes = 4'h1;
         LEAS_SZ2: size_bytes = 4'h2;
         LEAS_SZ4: size_bytes = 4'h4;
         default: size_bytes = 4'h8;
      endcase
   endfunction

   function automatic logic [2:0] munge_mask(input leas_size_e sz, input logic order);
      if (order == ORDER_BIG) begin
         munge_mask = XOR_8B;
      end else begin
         case (sz)
            LEAS_SZ1: munge_mask = XOR_1B;
            LEAS_SZ2: munge_mask = XOR_2B;
            LEAS_SZ4: munge_mask = XOR_4B;
            default: munge_mask = XOR_8B;
         endcase
      end
   endfunction

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      leas_state_e state;
      logic cur;
      logic hnd;
      logic [31:0] pc;
      logic [31:0] fetch_addr;
      logic [31:0] link;
      logic [31:0] saved_pc;
      logic mem_valid;
      logic [31:0] mem_addr;
      leas_size_e mem_size;
      logic mem_store;
      logic mem_direct;
      logic [63:0] mem_wdata;
      logic [31:0] base_ea;
      logic [2:0] byte_idx;
      logic [2:0] byte_last;
      logic [63:0] wdata_hold;
      logic resp_valid;
      logic resp_exc;
      logic [63:0] resp_rdata;
   } leas_regs_s;

   leas_regs_s r;
   leas_regs_s next_r;

   logic req_take;
   logic [3:0] req_cnt;
   logic req_mis;
   logic req_fits;
   logic req_nonscalar;
   logic [2:0] next_idx;
   logic [31:0] next_byte_addr;

   assign req_take = req_valid_in && (r.state == LEAS_IDLE);
   assign req_cnt = size_bytes(req_size_in);
   // Judged on the effective address, before any modification
   assign req_mis = |(req_ea_in[2:0] & (req_cnt[2:0] - 3'h1));
   assign req_fits = ({1'b0, req_ea_in[2:0]} + req_cnt) <= DWORD_BYTES;
   assign req_nonscalar = (req_class_in == LEAS_CL_MULTI) || (req_class_in == LEAS_CL_STRING);
   assign next_idx = r.byte_idx + 3'h1;
   assign next_byte_addr = r.base_ea + {29'h0, next_idx};

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      next_r = r;
      next_r.resp_valid = 1'b0;
      next_r.resp_exc = 1'b0;

      // Handler context wins over a plain mode write
      if (exc_take_in) begin
         next_r.cur = r.hnd;
      end else if (mode_write_in) begin
         next_r.cur = mode_cur_in;
         next_r.hnd = mode_hnd_in;
      end

      // Fetch side works wholly on unmodified addresses
      if (exc_take_in) begin
         next_r.saved_pc = r.pc;
         next_r.pc = exc_vector_in;
      end else if (branch_in) begin
         if (branch_link_in) begin
            next_r.link = r.pc + INSN_STEP;
         end
         if (branch_abs_in) begin
            next_r.pc = branch_target_in;
         end else begin
            next_r.pc = r.pc + branch_offset_in;
         end
      end else if (fetch_advance_in) begin
         next_r.pc = r.pc + INSN_STEP;
      end
      // Only the copy sent to memory is modified
      next_r.fetch_addr = next_r.pc ^ {29'h0, munge_mask(LEAS_SZ4, next_r.cur)};

      case (r.state)
         LEAS_IDLE: begin
            if (req_valid_in) begin
               if ((r.cur == ORDER_LITTLE) && req_nonscalar) begin
                  next_r.resp_valid = 1'b1;
                  next_r.resp_exc = 1'b1;
               end else if (req_class_in == LEAS_CL_BARRIER) begin
                  // Plain barrier carries no address
                  next_r.resp_valid = 1'b1;
               end else if ((r.cur == ORDER_LITTLE) && req_mis) begin
                  if (split_enable_in && req_fits) begin
                     next_r.state = LEAS_SPLIT;
                     next_r.base_ea = req_ea_in;
                     next_r.byte_idx = 3'h0;
                     next_r.byte_last = req_cnt[2:0] - 3'h1;
                     next_r.wdata_hold = req_wdata_in;
                     next_r.resp_rdata = 64'h0;
                     next_r.mem_valid = 1'b1;
                     next_r.mem_addr = req_ea_in ^ {29'h0, XOR_1B};
                     next_r.mem_size = LEAS_SZ1;
                     next_r.mem_store = req_store_in;
                     next_r.mem_direct = req_direct_in;
                     next_r.mem_wdata = {56'h0, req_wdata_in[7:0]};
                  end else begin
                     // Spanning two double words, or splitting off
                     next_r.resp_valid = 1'b1;
                     next_r.resp_exc = 1'b1;
                  end
               end else begin
                  next_r.state = LEAS_ISSUE;
                  next_r.mem_valid = 1'b1;
                  // Direct-store takes the same path as data
                  next_r.mem_addr = req_ea_in ^ {29'h0, munge_mask(req_size_in, r.cur)};
                  next_r.mem_size = req_size_in;
                  next_r.mem_store = req_store_in;
                  next_r.mem_direct = req_direct_in;
                  next_r.mem_wdata = req_wdata_in;
               end
            end
         end
         LEAS_ISSUE: begin
            if (mem_ready_in) begin
               next_r.state = LEAS_IDLE;
               next_r.mem_valid = 1'b0;
               next_r.resp_valid = 1'b1;
               next_r.resp_rdata = r.mem_store ? 64'h0 : mem_rdata_in;
            end
         end
         LEAS_SPLIT: begin
            if (mem_ready_in) begin
               if (!r.mem_store) begin
                  // Byte i of the value belongs at address ea+i
                  next_r.resp_rdata[{r.byte_idx, 3'h0} +: 8] = mem_rdata_in[7:0];
               end
               if (r.byte_idx == r.byte_last) begin
                  next_r.state = LEAS_IDLE;
                  next_r.mem_valid = 1'b0;
                  next_r.resp_valid = 1'b1;
               end else begin
                  next_r.byte_idx = next_idx;
                  next_r.mem_addr = next_byte_addr ^ {29'h0, XOR_1B};
                  next_r.mem_wdata = {56'h0, r.wdata_hold[{next_idx, 3'h0} +: 8]};
               end
            end
         end
         default: begin
            next_r.state = LEAS_IDLE;
            next_r.mem_valid = 1'b0;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk_in or posedge reset_in) begin
      if (reset_in) begin
         r <= '0;
         r.state <= LEAS_IDLE;
         r.cur <= RST_CUR_ORDER;
         r.hnd <= RST_HND_ORDER;
         r.pc <= RST_PC;
         r.fetch_addr <= RST_PC;
         r.mem_size <= LEAS_SZ1;
      end else begin
         r <= next_r;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign cur_order_out = r.cur;
   assign hnd_order_out = r.hnd;
   assign fetch_pc_out = r.pc;
   assign fetch_addr_out = r.fetch_addr;
   assign link_out = r.link;
   assign saved_pc_out = r.saved_pc;
   assign req_ready_out = (r.state == LEAS_IDLE);
   assign resp_valid_out = r.resp_valid;
   assign resp_align_exc_out = r.resp_exc;
   assign resp_rdata_out = r.resp_rdata;
   assign mem_valid_out = r.mem_valid;
   assign mem_addr_out = r.mem_addr;
   assign mem_size_out = r.mem_size;
   assign mem_store_out = r.mem_store;
   assign mem_direct_out = r.mem_direct;
   assign mem_wdata_out = r.mem_wdata;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   a_exc_mode_copy: assert property (
      @(posedge sys_clk_in) disable iff (reset_in)
      exc_take_in |=> (cur_order_out == $past(hnd_order_out)))
      else $error("current order not taken from handler bit");

   a_le_word_munge: assert property (
      @(posedge sys_clk_in) disable iff (reset_in)
      (req_take && r.cur && req_class_in == LEAS_CL_SINGLE && req_size_in == LEAS_SZ4 && !req_mis)
      |=> (mem_valid_out && mem_addr_out == ($past(req_ea_in) ^ 32'h0000_0004)))
      else $error("word address not modified by 0b100");

   a_be_no_munge: assert property (
      @(posedge sys_clk_in) disable iff (reset_in)
      (req_take && !r.cur && req_class_in == LEAS_CL_SINGLE)
      |=> (mem_valid_out && mem_addr_out == $past(req_ea_in)))
      else $error("big endian address was modified");

   a_data_unchanged: assert property (
      @(posedge sys_clk_in) disable iff (reset_in)
      (req_take && req_class_in == LEAS_CL_SINGLE && !(r.cur && req_mis))
      |=> (mem_wdata_out == $past(req_wdata_in)) throughout (mem_valid_out [*1]))
      else $error("store data altered on the way out");

   a_nonscalar_fault: assert property (
      @(posedge sys_clk_in) disable iff (reset_in)
      (req_take && r.cur && req_nonscalar)
      |=> (resp_valid_out && resp_align_exc_out && !mem_valid_out))
      else $error("multiple or string not faulted in little endian");

   a_mis_fault: assert property (
      @(posedge sys_clk_in) disable iff (reset_in)
      (req_take && r.cur && req_class_in == LEAS_CL_SINGLE && req_mis && !split_enable_in)
      |=> (resp_valid_out && resp_align_exc_out))
      else $error("misaligned little endian access not faulted");

   a_split_bytes: assert property (
      @(posedge sys_clk_in) disable iff (reset_in)
      (r.state == LEAS_SPLIT && mem_valid_out)
      |-> (mem_size_out == LEAS_SZ1 && mem_addr_out[2:0] == ((r.base_ea[2:0] + r.byte_idx) ^ 3'h7)))
      else $error("split byte at wrong address");

   a_split_done: assert property (
      @(posedge sys_clk_in) disable iff (reset_in)
      (req_take && r.cur && req_class_in == LEAS_CL_SINGLE && req_mis
       && split_enable_in && req_fits)
      |=> ##[1:80] (resp_valid_out && !resp_align_exc_out))
      else $error("split access did not finish in eighty cycles");

   a_fetch_step: assert property (
      @(posedge sys_clk_in) disable iff (reset_in)
      (fetch_advance_in && !branch_in && !exc_take_in)
      |=> (fetch_pc_out == $past(fetch_pc_out) + 32'h0000_0004))
      else $error("fetch did not step by four");

   a_fetch_munge: assert property (
      @(posedge sys_clk_in) disable iff (reset_in)
      fetch_addr_out == (fetch_pc_out ^ (cur_order_out ? 32'h0000_0004 : 32'h0000_0000)))
      else $error("fetch address modifier wrong");

   a_rel_branch: assert property (
      @(posedge sys_clk_in) disable iff (reset_in)
      (branch_in && !branch_abs_in && !exc_take_in)
      |=> (fetch_pc_out == $past(fetch_pc_out) + $past(branch_offset_in)))
      else $error("relative target not from own address");

   a_link_plain: assert property (
      @(posedge sys_clk_in) disable iff (reset_in)
      (branch_in && branch_link_in && !exc_take_in)
      |=> (link_out == $past(fetch_pc_out) + 32'h0000_0004))
      else $error("link value not the unmodified next address");

endmodule
